// [rtl/ssp_port.sv]
// Serial port end: register file, master clock generator and SPI shifter.
//
// Contract
// - Software sets enable before use
// - Disable, reconfigure, then re-enable
// - Direction bits match pin roles
// - Opposite direction overrides the serial function
// - Shift out one edge, sample other
// - Master starts on buffer write
// - Master with clock input keeps sampling
// - Slave shifts on external clock pulses
// - Clock idle follows polarity; MSB first
// - Master rate div 4, 16, 64, timer
// - Fastest master clock is quarter oscillator
// - Slave works while processor sleeps
// - Select gating only in mode 4 with input
// - Select low enables and drives output
// - Select high floats output mid-byte
// - Select low again resumes same bit
// - Select high resets slave logic (code only holds the bit count)
// - Slave with edge one needs select
// - Output direction input disables transmit
// - Four-bit mode field encoding
// - Byte to buffer sets full and irq
// - Busy write ignored, collision flag set
// - Slave overrun sets overflow, drops byte
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
module ssp_port (
  input wire logic clk,
  input wire logic reset,
  ssp_link_if.port_end link,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic tmr_tick,
  output logic irq_wake
);
  logic [7:0] con_q, stat_q, peripheral_irq_flags_1_q, peripheral_irq_enables_1_q, global_interrupt_control_q, dira_q, dirc_q, buf_q, sr_q;
  logic [2:0] cnt_q;
  logic busy_q, ph_q, sck_int_q, sdo_q, sdo_oe_q, sck_oe_q;
  logic [7:0] div_q;
  logic [1:0] sck_s, sdi_s, sel_s;
  logic sck_prev_q, half_toggle_q;
  logic en, clock_idle_polarity, cke, is_master, is_slave, sel_ctl, sel_high, edge_rise, edge_fall;
  logic shift_edge, sample_edge, done, wr_buf, rd_buf, master_tick;
  logic [7:0] half;
  ssp_pkg::ssp_mode_t mode;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detection.
  always_ff @(posedge clk)
  begin
    sck_s <= {sck_s[0], link.sck};
    sdi_s <= {sdi_s[0], link.serial_data_in};
    sel_s <= {sel_s[0], link.sel_n};
    sck_prev_q <= sck_s[1];
  end

  assign mode = ssp_pkg::ssp_mode_t'(con_q[3:0]);
  assign en = con_q[`SSP_CON_EN];
  assign clock_idle_polarity = con_q[`SSP_CON_CKP];
  assign cke = stat_q[`SSP_STAT_CKE];
  assign is_master = en && (con_q[3:2] == 2'b00);
  assign is_slave = en && (mode == ssp_pkg::SSP_MODE_S_SEL || mode == ssp_pkg::SSP_MODE_S_FREE);
  assign sel_ctl = is_slave && (mode == ssp_pkg::SSP_MODE_S_SEL) && dira_q[`SSP_DIRA_SEL];
  assign sel_high = sel_ctl && sel_s[1];
  assign edge_rise = sck_s[1] && !sck_prev_q;
  assign edge_fall = !sck_s[1] && sck_prev_q;
  assign wr_buf = reg_wr && (reg_addr == `SSP_OFS_BUF);
  assign rd_buf = reg_rd && (reg_addr == `SSP_OFS_BUF);

  ////////////////////////////////////////////////////////////////////////////
  // Master bit clock generator.
  // rate select
  always_comb
  begin
    unique case (con_q[1:0])
      2'b00: half = `SSP_HALF_DIV4;
      2'b01: half = `SSP_HALF_DIV16;
      2'b10: half = `SSP_HALF_DIV64;
      2'b11: half = 8'h01;
    endcase
  end

  // divide by 4 gives two-cycle half periods
  assign master_tick = (con_q[1:0] == 2'b11) ? (tmr_tick && div_q == 8'h00)
                                            : (div_q == half - 8'h01);

  always_ff @(posedge clk)
  begin
    if (reset || !busy_q || !is_master)
      div_q <= 8'h00;
    else if (con_q[1:0] == 2'b11)
      div_q <= 8'h00;
    else if (master_tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift and sample edges for both roles.
  // shift on programmed edge, sample on the other
  always_comb
  begin
    shift_edge = 1'b0;
    sample_edge = 1'b0;
    if (is_master && busy_q && master_tick)
    begin
      shift_edge = ph_q;
      sample_edge = !ph_q;
    end
    // slave moves only on external edges
    else if (is_slave && !sel_high)
    begin
      // The leading edge leaves the idle level and samples; the trailing edge shifts.
      shift_edge = clock_idle_polarity ? edge_rise : edge_fall;
      sample_edge = clock_idle_polarity ? edge_fall : edge_rise;
    end
  end

  assign done = sample_edge && (cnt_q == 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state: busy, phase, bit counter, shift register.
  always_ff @(posedge clk)
  begin
    // select high holds the bit count
    if (reset || !en)
    begin
      busy_q <= 1'b0;
      ph_q <= 1'b0;
      cnt_q <= 3'h0;
      sck_int_q <= 1'b0;
      sr_q <= 8'h00;
      sdo_q <= 1'b0;
    end
    else
    begin
      // buffer write starts the master at once
      if (wr_buf && !busy_q)
      begin
        busy_q <= 1'b1;
        sr_q <= reg_wdata;
        sdo_q <= reg_wdata[7];
        cnt_q <= 3'h0;
        ph_q <= 1'b0;
      end
      else
      begin
        if (is_slave && sample_edge && !busy_q)
          busy_q <= 1'b1;
        if (sample_edge)
        begin
          sr_q <= {sr_q[6:0], sdi_s[1]};
          cnt_q <= cnt_q + 3'h1;
        end
        if (shift_edge && !(is_master && cnt_q == 3'h0 && !ph_q))
          sdo_q <= sr_q[7];
        if (is_master && master_tick)
          ph_q <= !ph_q;
        if (done)
          busy_q <= 1'b0;
      end
      // clock idles at polarity level between bytes
      if (!is_master || !busy_q || done)
        sck_int_q <= clock_idle_polarity;
      else if (master_tick)
        sck_int_q <= !sck_int_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sck_oe_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end
    else
    begin
      // direction bit overrides the serial pin
      // clock input in master still runs the shifter
      sck_oe_q <= en && is_master && !dirc_q[`SSP_DIRC_SCK];
      // select high releases the slave output
      sdo_oe_q <= en && !dirc_q[`SSP_DIRC_SDO] && !sel_high;
    end
  end

  assign link.sck_o = sck_int_q;
  assign link.sck_oe = sck_oe_q;
  assign link.sdo_o = sdo_q;
  assign link.sdo_oe = sdo_oe_q;
  assign link.sel_n_o = 1'b0;
  assign link.sel_n_oe = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      con_q <= `SSP_RST_CON;
      stat_q <= `SSP_RST_STAT;
      peripheral_irq_flags_1_q <= `SSP_RST_PERIPHERAL_IRQ_FLAGS_1;
      peripheral_irq_enables_1_q <= `SSP_RST_PERIPHERAL_IRQ_ENABLES_1;
      global_interrupt_control_q <= `SSP_RST_GLOBAL_INTERRUPT_CONTROL;
      dira_q <= `SSP_RST_DIRA;
      dirc_q <= `SSP_RST_DIRC;
      buf_q <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == `SSP_OFS_CON)
        con_q[5:0] <= reg_wdata[5:0];
      if (reg_wr && reg_addr == `SSP_OFS_STAT)
        stat_q[7:6] <= reg_wdata[7:6];
      if (reg_wr && reg_addr == `SSP_OFS_PERIPHERAL_IRQ_ENABLES_1)
        peripheral_irq_enables_1_q <= reg_wdata;
      if (reg_wr && reg_addr == `SSP_OFS_GLOBAL_INTERRUPT_CONTROL)
        global_interrupt_control_q <= reg_wdata;
      if (reg_wr && reg_addr == `SSP_OFS_DIRA)
        dira_q <= {2'b00, reg_wdata[5:0]};
      if (reg_wr && reg_addr == `SSP_OFS_DIRC)
        dirc_q <= reg_wdata;
      if (reg_wr && reg_addr == `SSP_OFS_PERIPHERAL_IRQ_FLAGS_1)
        peripheral_irq_flags_1_q <= reg_wdata;
      if (wr_buf && !busy_q)
        buf_q <= reg_wdata;
      if (rd_buf)
        stat_q[`SSP_STAT_BF] <= 1'b0;
      // busy write flags collision; set beats clear
      if (reg_wr && reg_addr == `SSP_OFS_CON)
        con_q[`SSP_CON_WRITE_COLLISION_FLAG] <= reg_wdata[`SSP_CON_WRITE_COLLISION_FLAG];
      if (wr_buf && busy_q)
        con_q[`SSP_CON_WRITE_COLLISION_FLAG] <= 1'b1;
      if (reg_wr && reg_addr == `SSP_OFS_CON)
        con_q[`SSP_CON_OVF] <= reg_wdata[`SSP_CON_OVF];
      if (done)
      begin
        if (is_slave && stat_q[`SSP_STAT_BF] && !rd_buf)
          con_q[`SSP_CON_OVF] <= 1'b1;
        else
        begin
          // byte moves to buffer with flags
          buf_q <= {sr_q[6:0], sdi_s[1]};
          stat_q[`SSP_STAT_BF] <= 1'b1;
        end
        peripheral_irq_flags_1_q[`SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
      irq_wake <= 1'b0;
    end
    else
    begin
      // completion raises wake independent of processor state
      irq_wake <= peripheral_irq_flags_1_q[`SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ] && peripheral_irq_enables_1_q[`SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ];
      unique case (reg_addr)
        `SSP_OFS_BUF: reg_rdata <= buf_q;
        `SSP_OFS_CON: reg_rdata <= con_q;
        `SSP_OFS_STAT: reg_rdata <= stat_q;
        `SSP_OFS_PERIPHERAL_IRQ_FLAGS_1: reg_rdata <= peripheral_irq_flags_1_q;
        `SSP_OFS_PERIPHERAL_IRQ_ENABLES_1: reg_rdata <= peripheral_irq_enables_1_q;
        `SSP_OFS_GLOBAL_INTERRUPT_CONTROL: reg_rdata <= global_interrupt_control_q;
        `SSP_OFS_DIRA: reg_rdata <= dira_q;
        `SSP_OFS_DIRC: reg_rdata <= dirc_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : ssp_port
`default_nettype wire

// [rtl/ssp_defines.svh]
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_OFS_GLOBAL_INTERRUPT_CONTROL 8'h0b
`define SSP_OFS_PERIPHERAL_IRQ_FLAGS_1 8'h0c
`define SSP_OFS_BUF 8'h13
`define SSP_OFS_CON 8'h14
`define SSP_OFS_DIRA 8'h85
`define SSP_OFS_DIRC 8'h87
`define SSP_OFS_PERIPHERAL_IRQ_ENABLES_1 8'h8c
`define SSP_OFS_STAT 8'h94
`define SSP_CON_WRITE_COLLISION_FLAG 7
`define SSP_CON_OVF 6
`define SSP_CON_EN 5
`define SSP_CON_CKP 4
`define SSP_STAT_SMP 7
`define SSP_STAT_CKE 6
`define SSP_STAT_BF 0
`define SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ 3
`define SSP_DIRA_SEL 5
`define SSP_DIRC_SCK 3
`define SSP_DIRC_SDI 4
`define SSP_DIRC_SDO 5
`define SSP_RST_CON 8'h00
`define SSP_RST_STAT 8'h00
`define SSP_RST_PERIPHERAL_IRQ_FLAGS_1 8'h00
`define SSP_RST_PERIPHERAL_IRQ_ENABLES_1 8'h00
`define SSP_RST_GLOBAL_INTERRUPT_CONTROL 8'h00
`define SSP_RST_DIRA 8'h3f
`define SSP_RST_DIRC 8'hff
// Half bit periods in core cycles for divide by 4, 16 and 64.
`define SSP_HALF_DIV4 8'h02
`define SSP_HALF_DIV16 8'h08
`define SSP_HALF_DIV64 8'h20
`endif

// [rtl/ssp_pkg.sv]
// Types used by the port end of the serial port.
package ssp_pkg;
  typedef enum logic [3:0] {
    SSP_MODE_M_DIV4 = 4'h0,
    SSP_MODE_M_DIV16 = 4'h1,
    SSP_MODE_M_DIV64 = 4'h2,
    SSP_MODE_M_TMR = 4'h3,
    SSP_MODE_S_SEL = 4'h4,
    SSP_MODE_S_FREE = 4'h5
  } ssp_mode_t;
endpackage : ssp_pkg

// [rtl/ssp_link_if.sv]
// Pin-level link between the serial port and the far SPI party.
`timescale 1ns/1ns
`default_nettype none
interface ssp_link_if;
  logic sck_o;
  logic sck_oe;
  logic sdo_o;
  logic sdo_oe;
  logic sel_n_o;
  logic sel_n_oe;
  logic far_sck;
  logic far_sdo;
  logic far_sdo_oe;
  logic far_sel_n;
  logic sck;
  logic serial_data_in;
  logic sel_n;
  logic far_sdi;
  assign sck = sck_oe ? sck_o : far_sck;
  assign serial_data_in = far_sdo_oe ? far_sdo : 1'b0;
  assign sel_n = sel_n_oe ? sel_n_o : far_sel_n;
  assign far_sdi = sdo_oe ? sdo_o : 1'b0;
  modport port_end (
    output sck_o, sck_oe, sdo_o, sdo_oe, sel_n_o, sel_n_oe,
    input sck, serial_data_in, sel_n
  );
  modport far_end (
    output far_sck, far_sdo, far_sdo_oe, far_sel_n,
    input sck, far_sdi
  );
endinterface : ssp_link_if
`default_nettype wire

// [rtl/ssp_far.sv]
// Far end: a plain SPI master that clocks one byte per request.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
module ssp_far (
  input wire logic clk,
  input wire logic reset,
  ssp_link_if.far_end link,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic clock_idle_polarity,
  output logic busy,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  logic [7:0] sr_q, div_q;
  logic [3:0] cnt_q;
  logic sck_q, sdo_q, sel_q;
  logic [1:0] sdi_s;
  logic tick;

  // Half period of 8 core cycles keeps the port's sampler well inside a bit.
  assign tick = (div_q == `SSP_HALF_DIV16 - 8'h01);

  always_ff @(posedge clk)
  begin
    sdi_s <= {sdi_s[0], link.far_sdi};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sr_q <= 8'h00;
      div_q <= 8'h00;
      cnt_q <= 4'h0;
      sck_q <= 1'b0;
      sdo_q <= 1'b0;
      sel_q <= 1'b1;
      busy <= 1'b0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!busy)
      begin
        sck_q <= clock_idle_polarity;
        div_q <= 8'h00;
        if (start)
        begin
          busy <= 1'b1;
          sel_q <= 1'b0;
          sr_q <= tx_byte;
          sdo_q <= tx_byte[7];
          cnt_q <= 4'h0;
        end
      end
      else if (tick)
      begin
        div_q <= 8'h00;
        sck_q <= !sck_q;
        cnt_q <= cnt_q + 4'h1;
        // sample on leading edge, shift on trailing
        if (!cnt_q[0])
          sr_q <= {sr_q[6:0], sdi_s[1]};
        else if (cnt_q != 4'hf)
          sdo_q <= sr_q[7];
        if (cnt_q == 4'hf)
        begin
          busy <= 1'b0;
          sel_q <= 1'b1;
          rx_byte <= sr_q;
          rx_valid <= 1'b1;
        end
      end
      else
        div_q <= div_q + 8'h01;
    end
  end

  assign link.far_sck = sck_q;
  assign link.far_sdo = sdo_q;
  assign link.far_sdo_oe = 1'b1;
  assign link.far_sel_n = sel_q;
endmodule : ssp_far
`default_nettype wire

// [dv/ssp_link_monitor.sv]
// Concurrent checks on the pin-level link between the two serial ends.
`timescale 1ns/1ns
`default_nettype none
module ssp_link_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sel_n_oe,
  input wire logic far_sdo,
  input wire logic far_sdo_oe,
  input wire logic far_sel_n,
  input wire logic sck,
  input wire logic serial_data_in,
  input wire logic sel_n,
  input wire logic far_sdi
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  AST_SEL_INPUT: assert property (!sel_n_oe)
    else $error("select pin driven by the port");
  AST_SEL_FLOAT: assert property (!sck_oe && sel_n [*4] |-> !sdo_oe)
    else $error("data out still driven while deselected");
  AST_HALF_MIN: assert property (sck_oe && $past(sck_oe) && $changed(sck_o) |=> $stable(sck_o))
    else $error("master clock half period below two cycles");
  AST_SCK_WIRE: assert property (sck_oe |-> sck == sck_o)
    else $error("clock wire differs from master drive");
  AST_SDO_WIRE: assert property (sdo_oe |-> far_sdi == sdo_o)
    else $error("data out wire differs from port drive");
  AST_SDO_IDLE: assert property (!sdo_oe |-> !far_sdi)
    else $error("released data out wire not at rest level");
  AST_SDI_WIRE: assert property (far_sdo_oe |-> serial_data_in == far_sdo)
    else $error("data in wire differs from far drive");
  AST_SEL_WIRE: assert property (!sel_n_oe |-> sel_n == far_sel_n)
    else $error("select wire differs from far drive");
endmodule : ssp_link_monitor
`default_nettype wire

// [dv/spi_mode_serial_port_tb.sv]
// Self-checking bench joining the serial port to the far SPI master.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module spi_mode_serial_port_tb;
  typedef struct packed {logic clock_idle_polarity; logic [7:0] ptx; logic [7:0] ftx;} ssp_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic tmr_tick = 1'b0;
  logic irq_wake;
  logic start = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic clock_idle_polarity = 1'b0;
  logic busy;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] d;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  ssp_row_t rows [4] = '{'{1'b0, 8'ha5, 8'h3c}, '{1'b1, 8'h81, 8'h7e},
                         '{1'b0, 8'h00, 8'hff}, '{1'b1, 8'hff, 8'h01}};
  logic [7:0] ra [7] = '{`SSP_OFS_CON, `SSP_OFS_STAT, `SSP_OFS_PERIPHERAL_IRQ_FLAGS_1, `SSP_OFS_PERIPHERAL_IRQ_ENABLES_1,
                         `SSP_OFS_DIRA, `SSP_OFS_DIRC, 8'h20};
  logic [7:0] re [7] = '{`SSP_RST_CON, `SSP_RST_STAT, `SSP_RST_PERIPHERAL_IRQ_FLAGS_1, `SSP_RST_PERIPHERAL_IRQ_ENABLES_1,
                         `SSP_RST_DIRA, `SSP_RST_DIRC, 8'h00};
  logic [3:0] mm [3] = '{4'h0, 4'h1, 4'h3};
  int lo [3] = '{12, 57, 26};
  int hi [3] = '{18, 63, 34};
  ssp_link_if link ();
  ssp_port u_ssp_port (.clk(clk), .reset(reset), .link(link.port_end), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tmr_tick(tmr_tick), .irq_wake(irq_wake));
  ssp_far u_ssp_far (.clk(clk), .reset(reset), .link(link.far_end), .start(start),
    .tx_byte(tx_byte), .clock_idle_polarity(clock_idle_polarity), .busy(busy), .rx_byte(rx_byte), .rx_valid(rx_valid));
  ssp_link_monitor u_ssp_link_monitor (.clk(clk), .reset(reset), .sck_o(link.sck_o),
    .sck_oe(link.sck_oe), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
    .sel_n_oe(link.sel_n_oe), .far_sdo(link.far_sdo), .far_sdo_oe(link.far_sdo_oe),
    .far_sel_n(link.far_sel_n), .sck(link.sck), .serial_data_in(link.serial_data_in), .sel_n(link.sel_n),
    .far_sdi(link.far_sdi));
  always #4 clk = ~clk;
  // The period timer ticks once every four core cycles.
  always @(negedge clk)
  begin
    tmr_tick <= (cycles % 4 == 0);
  end
  ////////////////////////////////////////////////////////////////////////////
  task results;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end
  task do_reset;
    @(negedge clk) reset = 1'b1;
    repeat (20) @(negedge clk);
    reset = 1'b0;
  endtask : do_reset
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk) reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk) reg_rd = 1'b0;
    v = reg_rdata;
  endtask : rd
  // The far master clocks one byte; the port sees it through its synchronisers.
  task far_xfer(input logic [7:0] b);
    @(negedge clk);
    tx_byte = b;
    start = 1'b1;
    @(negedge clk) start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(busy, 1'b0)
    repeat (8) @(negedge clk);
  endtask : far_xfer
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    // slave rows keep select control on.
    wr(`SSP_OFS_DIRC, 8'hdf);
    foreach (rows[i])
    begin
      clock_idle_polarity = rows[i].clock_idle_polarity;
      wr(`SSP_OFS_CON, 8'h00);
      wr(`SSP_OFS_CON, {3'b001, rows[i].clock_idle_polarity, 4'h4});
      wr(`SSP_OFS_BUF, rows[i].ptx);
      far_xfer(rows[i].ftx);
      `CHK(rx_byte, rows[i].ptx)
      rd(`SSP_OFS_STAT, d);
      `CHK(d[`SSP_STAT_BF], 1'b1)
      rd(`SSP_OFS_PERIPHERAL_IRQ_FLAGS_1, d);
      `CHK(d[`SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ], 1'b1)
      rd(`SSP_OFS_BUF, d);
      `CHK(d, rows[i].ftx)
      rd(`SSP_OFS_STAT, d);
      `CHK(d[`SSP_STAT_BF], 1'b0)
      wr(`SSP_OFS_PERIPHERAL_IRQ_FLAGS_1, 8'h00);
    end
    $display("test slave rows done");
    far_xfer(8'h11);
    far_xfer(8'h22);
    rd(`SSP_OFS_CON, d);
    `CHK(d[`SSP_CON_OVF], 1'b1)
    rd(`SSP_OFS_BUF, d);
    `CHK(d, 8'h11)
    $display("test overflow done");
    do_reset();
    foreach (ra[k])
    begin
      rd(ra[k], d);
      `CHK(d, re[k])
    end
    $display("test reset values done");
    wr(`SSP_OFS_DIRC, 8'hd7);
    wr(`SSP_OFS_CON, 8'h32);
    repeat (2) @(negedge clk);
    `CHK(link.sck, 1'b1)
    wr(`SSP_OFS_BUF, 8'h96);
    @(negedge clk);
    `CHK(link.far_sdi, 1'b1)
    wr(`SSP_OFS_BUF, 8'h00);
    rd(`SSP_OFS_CON, d);
    `CHK(d[`SSP_CON_WRITE_COLLISION_FLAG], 1'b1)
    repeat (400) @(negedge clk);
    rd(`SSP_OFS_PERIPHERAL_IRQ_FLAGS_1, d);
    `CHK(d[`SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ], 1'b0)
    n = 0;
    while (d[`SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ] !== 1'b1 && n < 600)
    begin
      rd(`SSP_OFS_PERIPHERAL_IRQ_FLAGS_1, d);
      n++;
    end
    `CHK(d[`SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ], 1'b1)
    rd(`SSP_OFS_CON, d);
    `CHK(d[`SSP_CON_OVF], 1'b0)
    rd(`SSP_OFS_BUF, d);
    `CHK(d, 8'h00)
    wr(`SSP_OFS_PERIPHERAL_IRQ_ENABLES_1, 8'h08);
    repeat (2) @(negedge clk);
    `CHK(irq_wake, 1'b1)
    wr(`SSP_OFS_PERIPHERAL_IRQ_FLAGS_1, 8'h00);
    repeat (2) @(negedge clk);
    `CHK(irq_wake, 1'b0)
    $display("test master done");
    foreach (mm[j])
    begin
      wr(`SSP_OFS_CON, 8'h00);
      wr(`SSP_OFS_CON, {4'h2, mm[j]});
      rd(`SSP_OFS_BUF, d);
      wr(`SSP_OFS_PERIPHERAL_IRQ_FLAGS_1, 8'h00);
      wr(`SSP_OFS_BUF, 8'h5a);
      n = 0;
      d = 8'h00;
      while (d[`SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ] !== 1'b1 && n < 200)
      begin
        rd(`SSP_OFS_PERIPHERAL_IRQ_FLAGS_1, d);
        n++;
      end
      `CHK(n >= lo[j] && n <= hi[j], 1'b1)
      `CHK(d[`SSP_PERIPHERAL_IRQ_FLAGS_1_IRQ], 1'b1)
    end
    $display("test master rates done");
    results();
  end
endmodule : spi_mode_serial_port_tb
`default_nettype wire
